// file: tvmb_channel.sv
`timescale 1ns/100ps
// Behaviour
// - Bit mapping drives one coil from the evaluated value.
// - Bit-in-word mapping changes only the selected bit of the word.
// - Value mapping places a translated value inside the word register.
// - Each received value is compared with a 16-bit reference: higher, equal, lower.
// - Per outcome, the bit is left, written one or written zero.
// - Bit writes use function 05 at the configured address.
// - Bit reads use function 01 or 02 as configured.
// - A set polled bit sends the configured value or nothing.
// - A clear polled bit sends the other configured value or nothing.
// - A bit-position setting picks the word bit, counted from bit zero.
// - Per outcome, the selected word bit is left, set or cleared.
// - Word updates use function 06 at the configured address.
// - Polled word reads use function 03 or 04 as configured; the read before a word update always uses 03.
// - A set selected word bit sends its set value or nothing.
// - A clear selected word bit sends its clear value or nothing.
// - A bit count sets the field width in the word.
// - An offset places the field's low bit, counted from bit zero.
// - Per outcome, the value field is left or written with its value.
module tvmb_channel (
  input wire logic clock,
  input wire logic resetn,
  input tvmb_pkg::tvmb_cfg_t cfg,
  input wire logic knx_rx_valid,
  input wire logic [15:0] knx_rx_value,
  output logic knx_rx_ready,
  output logic knx_tx_valid,
  output logic [15:0] knx_tx_value,
  input wire logic poll_tick,
  output logic mb_req_valid,
  output tvmb_pkg::tvmb_req_t mb_req,
  input wire logic mb_req_ready,
  input wire logic mb_rsp_valid,
  input wire logic mb_rsp_err,
  input wire logic [15:0] mb_rsp_data,
  output tvmb_pkg::tvmb_cmp_t last_outcome
);
  import tvmb_pkg::*;

  tvmb_state_t state_r, state_nxt;
  logic req_valid_r, req_valid_nxt;
  tvmb_req_t req_r, req_nxt;
  tvmb_act_t act_r, act_nxt;
  logic [15:0] fval_r, fval_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [15:0] tx_value_r, tx_value_nxt;
  logic prev_bit_r, prev_bit_nxt;
  logic seen_r, seen_nxt;
  logic rx_ready_r, rx_ready_nxt;
  tvmb_cmp_t outcome_r, outcome_nxt;

  // ---------------------------------------------------------------
  // Evaluation of the incoming value
  // ---------------------------------------------------------------
  logic knx_take;
  logic poll_take;
  tvmb_cmp_t cmp;
  tvmb_act_t act_sel;
  logic [15:0] val_sel;
  logic [15:0] bit_mask;
  logic [15:0] fld_mask;
  logic [15:0] merged;
  logic polled_bit;
  logic send_ok;
  logic [7:0] rd_func;

  // Request acceptance in idle only
  assign knx_take = (state_r == ST_IDLE) && knx_rx_valid && (cfg.dir == DIR_KNX_TO_MB);
  assign poll_take = (state_r == ST_IDLE) && poll_tick && (cfg.dir == DIR_MB_TO_KNX);

  // Three-way compare and per-outcome selection
  always_comb
  begin
    if (knx_rx_value > cfg.ref_value)
    begin
      cmp = CMP_HIGHER;
      act_sel = cfg.act_hi;
      val_sel = cfg.val_hi;
    end
    else if (knx_rx_value == cfg.ref_value)
    begin
      cmp = CMP_EQUAL;
      act_sel = cfg.act_eq;
      val_sel = cfg.val_eq;
    end
    else
    begin
      cmp = CMP_LOWER;
      act_sel = cfg.act_lo;
      val_sel = cfg.val_lo;
    end
  end

  // Masks for the selected bit and the value field
  assign bit_mask = WORD_ONE << cfg.bit_pos;
  assign fld_mask = 16'((17'((FIELD_ONE << cfg.fld_width) - FIELD_ONE)) << cfg.fld_off);

  // Read-modify-write of the fetched word
  always_comb
  begin
    merged = mb_rsp_data;
    if (cfg.mode == MODE_BIT_IN_WORD)
    begin
      if (act_r == ACT_ONE)
        merged = mb_rsp_data | bit_mask;
      else if (act_r == ACT_ZERO)
        merged = mb_rsp_data & ~bit_mask;
    end
    else if (act_r == ACT_ONE)
      merged = (mb_rsp_data & ~fld_mask) | ((fval_r << cfg.fld_off) & fld_mask);
  end

  // Polled state and send decision
  assign polled_bit = (cfg.mode == MODE_BIT) ? mb_rsp_data[0] : mb_rsp_data[cfg.bit_pos];
  assign send_ok = (polled_bit ? cfg.send_set : cfg.send_clr)
    && (!cfg.on_change || !seen_r || (polled_bit != prev_bit_r));

  // Read function for the polling direction
  always_comb
  begin
    if (cfg.mode == MODE_BIT)
      rd_func = cfg.rd_alt ? FC_READ_DISCRETE : FC_READ_COILS;
    else
      rd_func = cfg.rd_alt ? FC_READ_INPUT : FC_READ_HOLDING;
  end

  // ---------------------------------------------------------------
  // Transaction sequencer
  // ---------------------------------------------------------------

  // Next-state logic
  always_comb
  begin
    state_nxt = state_r;
    req_valid_nxt = req_valid_r;
    req_nxt = req_r;
    act_nxt = act_r;
    fval_nxt = fval_r;
    tx_valid_nxt = 1'b0;
    tx_value_nxt = tx_value_r;
    prev_bit_nxt = prev_bit_r;
    seen_nxt = seen_r;
    outcome_nxt = outcome_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (knx_take)
        begin
          outcome_nxt = cmp;
          act_nxt = act_sel;
          fval_nxt = val_sel;
          if (act_sel != ACT_NONE)
          begin
            req_valid_nxt = 1'b1;
            req_nxt.addr = cfg.addr;
            if (cfg.mode == MODE_BIT)
            begin
              req_nxt.func = FC_WRITE_COIL;
              req_nxt.data = (act_sel == ACT_ONE) ? COIL_ON : COIL_OFF;
              state_nxt = ST_WR;
            end
            else
            begin
              req_nxt.func = FC_READ_HOLDING;
              req_nxt.data = WORD_ZERO;
              state_nxt = ST_RD;
            end
          end
        end
        else if (poll_take)
        begin
          req_valid_nxt = 1'b1;
          req_nxt.addr = cfg.addr;
          req_nxt.func = rd_func;
          req_nxt.data = WORD_ZERO;
          state_nxt = ST_RD;
        end
      end
      ST_RD:
      begin
        if (mb_req_ready)
        begin
          req_valid_nxt = 1'b0;
          state_nxt = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT:
      begin
        if (mb_rsp_valid)
        begin
          state_nxt = ST_IDLE;
          if (mb_rsp_err)
            state_nxt = ST_IDLE;
          else if (cfg.dir == DIR_KNX_TO_MB)
          begin
            req_valid_nxt = 1'b1;
            req_nxt.func = FC_WRITE_HOLDING;
            req_nxt.data = merged;
            state_nxt = ST_WR;
          end
          else if (cfg.mode != MODE_VALUE)
          begin
            prev_bit_nxt = polled_bit;
            seen_nxt = 1'b1;
            if (send_ok)
            begin
              tx_valid_nxt = 1'b1;
              tx_value_nxt = polled_bit ? cfg.val_set : cfg.val_clr;
            end
          end
        end
      end
      ST_WR:
      begin
        if (mb_req_ready)
        begin
          req_valid_nxt = 1'b0;
          state_nxt = ST_WR_WAIT;
        end
      end
      ST_WR_WAIT:
      begin
        if (mb_rsp_valid)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        req_valid_nxt = 1'b0;
      end
    endcase
    rx_ready_nxt = (state_nxt == ST_IDLE);
  end

  // State registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      req_valid_r <= 1'b0;
      req_r <= '0;
      act_r <= ACT_NONE;
      fval_r <= WORD_ZERO;
      tx_valid_r <= 1'b0;
      tx_value_r <= WORD_ZERO;
      prev_bit_r <= 1'b0;
      seen_r <= 1'b0;
      rx_ready_r <= 1'b1;
      outcome_r <= CMP_EQUAL;
    end
    else
    begin
      state_r <= state_nxt;
      req_valid_r <= req_valid_nxt;
      req_r <= req_nxt;
      act_r <= act_nxt;
      fval_r <= fval_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_value_r <= tx_value_nxt;
      prev_bit_r <= prev_bit_nxt;
      seen_r <= seen_nxt;
      rx_ready_r <= rx_ready_nxt;
      outcome_r <= outcome_nxt;
    end
  end

  // Outputs straight from flops
  assign knx_rx_ready = rx_ready_r;
  assign knx_tx_valid = tx_valid_r;
  assign knx_tx_value = tx_value_r;
  assign mb_req_valid = req_valid_r;
  assign mb_req = req_r;
  assign last_outcome = outcome_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence rsp_ok_s;
    state_r == ST_RD_WAIT && mb_rsp_valid && !mb_rsp_err;
  endsequence

  sequence poll_done_s;
    rsp_ok_s ##0 cfg.dir == DIR_MB_TO_KNX && cfg.mode != MODE_VALUE;
  endsequence

  coil_write_one_a: assert property (@(posedge clock) disable iff (!resetn)
    knx_take && cfg.mode == MODE_BIT && act_sel == ACT_ONE |=> mb_req_valid
    && mb_req.func == 8'h05 && mb_req.data == 16'hff00 && mb_req.addr == $past(cfg.addr))
    else $error("coil write not issued as expected");

  no_reaction_a: assert property (@(posedge clock) disable iff (!resetn)
    knx_take && act_sel == ACT_NONE |=> !mb_req_valid && state_r == ST_IDLE)
    else $error("request issued on no reaction");

  outcome_cmp_a: assert property (@(posedge clock) disable iff (!resetn)
    knx_take && knx_rx_value > cfg.ref_value |=> last_outcome == CMP_HIGHER)
    else $error("higher outcome not recorded");

  word_write_a: assert property (@(posedge clock) disable iff (!resetn)
    rsp_ok_s ##0 cfg.dir == DIR_KNX_TO_MB |=> mb_req_valid && mb_req.func == 8'h06)
    else $error("word write not issued after read");

  bit_only_a: assert property (@(posedge clock) disable iff (!resetn)
    rsp_ok_s ##0 cfg.dir == DIR_KNX_TO_MB && cfg.mode == MODE_BIT_IN_WORD
    |=> (mb_req.data & ~bit_mask) == ($past(mb_rsp_data) & ~bit_mask))
    else $error("bits other than the selected one changed");

  field_write_a: assert property (@(posedge clock) disable iff (!resetn)
    rsp_ok_s ##0 cfg.dir == DIR_KNX_TO_MB && cfg.mode == MODE_VALUE && act_r == ACT_ONE
    |=> (mb_req.data & fld_mask) == ((fval_r << cfg.fld_off) & fld_mask))
    else $error("field value not placed in word");

  poll_read_a: assert property (@(posedge clock) disable iff (!resetn)
    poll_take && cfg.mode == MODE_BIT |=> mb_req_valid
    && mb_req.func == ($past(cfg.rd_alt) ? 8'h02 : 8'h01))
    else $error("wrong bit read function");

  word_read_a: assert property (@(posedge clock) disable iff (!resetn)
    poll_take && cfg.mode != MODE_BIT |=> mb_req_valid
    && mb_req.func == ($past(cfg.rd_alt) ? 8'h04 : 8'h03))
    else $error("wrong word read function");

  send_set_a: assert property (@(posedge clock) disable iff (!resetn)
    poll_done_s ##0 polled_bit && cfg.send_set && !cfg.on_change
    |=> knx_tx_valid && knx_tx_value == $past(cfg.val_set))
    else $error("set value not sent");

  on_change_a: assert property (@(posedge clock) disable iff (!resetn)
    poll_done_s ##0 cfg.on_change && seen_r && polled_bit == prev_bit_r |=> !knx_tx_valid)
    else $error("sent without a state change");

endmodule

// file: tvmb_pkg.sv
package tvmb_pkg;

  // ---------------------------------------------------------------
  // Modbus function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_HOLDING = 8'h06;

  // ---------------------------------------------------------------
  // Data words, reset values and directions
  // ---------------------------------------------------------------
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [16:0] FIELD_ONE = 17'h00001;
  localparam logic DIR_KNX_TO_MB = 1'b0;
  localparam logic DIR_MB_TO_KNX = 1'b1;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BIT = 2'h0,
    MODE_BIT_IN_WORD = 2'h1,
    MODE_VALUE = 2'h2
  } tvmb_mode_t;

  // For value mode ACT_ONE means write the configured field value
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_ONE = 2'h1,
    ACT_ZERO = 2'h2
  } tvmb_act_t;

  typedef enum logic [1:0] {
    CMP_LOWER = 2'h0,
    CMP_EQUAL = 2'h1,
    CMP_HIGHER = 2'h2
  } tvmb_cmp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RD_WAIT = 3'h3,
    ST_WR = 3'h2,
    ST_WR_WAIT = 3'h6
  } tvmb_state_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    tvmb_mode_t mode;
    logic dir;
    logic on_change;
    logic rd_alt;
    logic [15:0] ref_value;
    tvmb_act_t act_hi;
    tvmb_act_t act_eq;
    tvmb_act_t act_lo;
    logic [15:0] val_hi;
    logic [15:0] val_eq;
    logic [15:0] val_lo;
    logic [3:0] bit_pos;
    logic [4:0] fld_width;
    logic [3:0] fld_off;
    logic send_set;
    logic send_clr;
    logic [15:0] val_set;
    logic [15:0] val_clr;
    logic [15:0] addr;
  } tvmb_cfg_t;

  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } tvmb_req_t;

endpackage

// file: tvmb_slave.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Modbus slave model
// ---------------------------------------------
module tvmb_slave (
  input wire logic clock,
  input wire logic mb_req_valid,
  input tvmb_pkg::tvmb_req_t mb_req,
  output logic mb_req_ready,
  output logic mb_rsp_valid,
  output logic mb_rsp_err,
  output logic [15:0] mb_rsp_data
);
  import tvmb_pkg::*;
  logic [15:0] words [16];
  logic coils [16];
  logic [7:0] last_func;
  logic [15:0] rd;
  bit fail_next;
  int reqs;
  tvmb_req_t q;
  // One request at a time, slow or prompt answer
  initial
  begin
    mb_req_ready = 1'b0;
    mb_rsp_valid = 1'b0;
    mb_rsp_err = 1'b0;
    mb_rsp_data = 16'h5a5a;
    last_func = 8'h00;
    fail_next = 1'b0;
    reqs = 0;
    forever
    begin
      @(posedge clock);
      if (mb_req_valid === 1'b1)
      begin
        repeat ($urandom_range(3)) @(posedge clock);
        mb_req_ready <= 1'b1;
        @(posedge clock);
        q = mb_req;
        mb_req_ready <= 1'b0;
        last_func = q.func;
        reqs++;
        rd = words[q.addr[3:0]];
        if (q.func == FC_READ_COILS || q.func == FC_READ_DISCRETE)
          rd = {15'h0000, coils[q.addr[3:0]]};
        if (q.func == FC_WRITE_COIL)
          coils[q.addr[3:0]] = (q.data == COIL_ON);
        if (q.func == FC_WRITE_HOLDING)
          words[q.addr[3:0]] = q.data;
        repeat ($urandom_range(3, 1)) @(posedge clock);
        mb_rsp_valid <= 1'b1;
        mb_rsp_err <= fail_next;
        mb_rsp_data <= rd;
        fail_next = 1'b0;
        @(posedge clock);
        mb_rsp_valid <= 1'b0;
        mb_rsp_err <= 1'b0;
        mb_rsp_data <= ~rd;
      end
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import tvmb_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  tvmb_cfg_t cfg = '0;
  logic knx_rx_valid = 1'b0;
  logic [15:0] knx_rx_value = 16'h0000;
  logic poll_tick = 1'b0;
  logic knx_rx_ready, knx_tx_valid, mb_req_valid, mb_req_ready, mb_rsp_valid, mb_rsp_err;
  logic [15:0] knx_tx_value, mb_rsp_data;
  tvmb_req_t mb_req;
  tvmb_cmp_t last_outcome;
  int err_total = 0;
  int checked = 0;
  bit first = 1'b1;
  logic prev_st;

  // ---------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------
  always #2.5 clock = ~clock;

  tvmb_channel dut (.clock, .resetn, .cfg, .knx_rx_valid, .knx_rx_value, .knx_rx_ready,
    .knx_tx_valid, .knx_tx_value, .poll_tick, .mb_req_valid, .mb_req, .mb_req_ready,
    .mb_rsp_valid, .mb_rsp_err, .mb_rsp_data, .last_outcome);

  tvmb_slave slv (.clock, .mb_req_valid, .mb_req, .mb_req_ready, .mb_rsp_valid,
    .mb_rsp_err, .mb_rsp_data);

  // Compare and count
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for the channel to go idle
  task automatic wait_ready();
    for (int n = 0; n < 200 && knx_rx_ready !== 1'b1; n++)
      @(negedge clock);
    check("rx_ready", 16'(knx_rx_ready), 16'h0001);
  endtask

  // One group value into the channel
  task automatic knx_send(logic [15:0] v);
    wait_ready();
    knx_rx_valid = 1'b1;
    knx_rx_value = v;
    @(negedge clock);
    knx_rx_valid = 1'b0;
    knx_rx_value = ~v;
    repeat (3) @(negedge clock);
    wait_ready();
  endtask

  // Target coil or word in the model
  function automatic logic [15:0] mem_at(tvmb_mode_t m);
    return (m == MODE_BIT) ? 16'(slv.coils[cfg.addr[3:0]]) : slv.words[cfg.addr[3:0]];
  endfunction

  // Group value toward Modbus, all outcomes
  task automatic k2m(tvmb_mode_t m, int n);
    logic [15:0] v, old, msk, fv, exp;
    tvmb_cmp_t oc;
    tvmb_act_t a;
    int top;
    top = (m == MODE_VALUE) ? 1 : 2;
    for (int i = 0; i < n; i++)
    begin
      cfg = '0;
      cfg.mode = m;
      cfg.addr = 16'($urandom_range(15));
      cfg.ref_value = 16'($urandom_range(65534, 1));
      cfg.act_hi = tvmb_act_t'($urandom_range(top));
      cfg.act_eq = tvmb_act_t'($urandom_range(top));
      cfg.act_lo = tvmb_act_t'($urandom_range(top));
      cfg.bit_pos = 4'($urandom);
      cfg.fld_width = 5'($urandom_range(16, 1));
      cfg.fld_off = 4'($urandom_range(16 - cfg.fld_width));
      msk = 16'((17'h00001 << cfg.fld_width) - 17'h00001);
      cfg.val_hi = 16'($urandom) & msk;
      cfg.val_eq = 16'($urandom) & msk;
      cfg.val_lo = 16'($urandom) & msk;
      oc = tvmb_cmp_t'(i % 3);
      v = cfg.ref_value + 16'(i % 3) - 16'h0001;
      a = (oc == CMP_HIGHER) ? cfg.act_hi : (oc == CMP_EQUAL) ? cfg.act_eq : cfg.act_lo;
      fv = (oc == CMP_HIGHER) ? cfg.val_hi : (oc == CMP_EQUAL) ? cfg.val_eq : cfg.val_lo;
      old = mem_at(m);
      exp = old;
      if (a != ACT_NONE && m == MODE_BIT)
        exp = 16'(a == ACT_ONE);
      if (a != ACT_NONE && m == MODE_BIT_IN_WORD)
        exp[cfg.bit_pos] = (a == ACT_ONE);
      if (a == ACT_ONE && m == MODE_VALUE)
        exp = (old & ~(msk << cfg.fld_off)) | (fv << cfg.fld_off);
      slv.last_func = 8'h00;
      knx_send(v);
      check("outcome", 16'(last_outcome), 16'(oc));
      check("target", mem_at(m), exp);
      check("wr_func", 16'(slv.last_func), (a == ACT_NONE) ? 16'h0000 :
        (m == MODE_BIT) ? 16'(FC_WRITE_COIL) : 16'(FC_WRITE_HOLDING));
    end
  endtask

  // Polled state toward the group object
  task automatic m2k(tvmb_mode_t m, logic alt, logic oc_en, int n);
    logic st, snd, bad;
    logic [15:0] got, fc;
    int cnt;
    logic [15:0] exp_q[$];
    fc = 16'(m == MODE_BIT ? (alt ? FC_READ_DISCRETE : FC_READ_COILS) :
      (alt ? FC_READ_INPUT : FC_READ_HOLDING));
    for (int i = 0; i < n; i++)
    begin
      cfg = '0;
      cfg.dir = DIR_MB_TO_KNX;
      cfg.mode = m;
      cfg.rd_alt = alt;
      cfg.on_change = oc_en;
      cfg.addr = 16'($urandom_range(15));
      cfg.bit_pos = 4'($urandom);
      cfg.send_set = 1'($urandom);
      cfg.send_clr = 1'($urandom);
      cfg.val_set = 16'($urandom);
      cfg.val_clr = 16'($urandom);
      st = 1'($urandom);
      if (m == MODE_BIT)
        slv.coils[cfg.addr[3:0]] = st;
      else
        slv.words[cfg.addr[3:0]][cfg.bit_pos] = st;
      bad = (i == 2);
      slv.fail_next = bad;
      slv.reqs = 0;
      snd = (st ? cfg.send_set : cfg.send_clr) && (!oc_en || first || st != prev_st)
        && !bad && m != MODE_VALUE;
      if (snd)
        exp_q.push_back(st ? cfg.val_set : cfg.val_clr);
      poll_tick = 1'b1;
      @(negedge clock);
      poll_tick = 1'b0;
      cnt = 0;
      got = 16'h0000;
      repeat (30)
      begin
        @(negedge clock);
        if (knx_tx_valid === 1'b1)
        begin
          cnt++;
          got = knx_tx_value;
          if (exp_q.size() > 0)
            check("tx_model", knx_tx_value, exp_q.pop_front());
        end
      end
      if (!bad && m != MODE_VALUE)
      begin
        first = 1'b0;
        prev_st = st;
      end
      check("tx_count", 16'(cnt), 16'(snd));
      if (snd)
        check("tx_value", got, st ? cfg.val_set : cfg.val_clr);
      check("rd_func", 16'(slv.last_func), fc);
      check("rd_count", 16'(slv.reqs), 16'h0001);
      check("tx_queue", 16'(exp_q.size()), 16'h0000);
      exp_q.delete();
    end
  endtask

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial
  begin
    void'($urandom(7));
    for (int i = 0; i < 16; i++)
    begin
      slv.words[i] = 16'($urandom);
      slv.coils[i] = 1'($urandom);
    end
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    check("outcome_rst", 16'(last_outcome), 16'(CMP_EQUAL));
    k2m(MODE_BIT, 12);
    k2m(MODE_BIT_IN_WORD, 12);
    k2m(MODE_VALUE, 12);
    for (int j = 0; j < 8; j++)
      m2k(j[1] ? MODE_BIT_IN_WORD : MODE_BIT, j[0], j[2], 6);
    m2k(MODE_VALUE, 1'b1, 1'b0, 3);
    stop_test();
  end

  // Watchdog against a hang
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule
